// ===== fps_defines.svh
// constants of the flash program and program-once sequencer
// Overview of operation
// R1: program-phrase launched with index pointer not 101 sets access error
// R2: command not allowed in current mode sets access error, nothing runs
// R3: program address outside program flash range sets access error
// R4: program address with low three bits not 000 sets access error
// R5: program address inside protected region sets protection violation, no programming
// R6: any error during read-back verify sets verify error status
// R7: uncorrectable error during verify sets uncorrectable verify status
// R8: program-once writes only the 64-byte, 8-phrase one-time field
// R9: one-time field never erased; second program of a phrase refused
// R10: software loads 0x07, phrase index, then four data words at 010-101
// R11: software supplies phrase index 0 to 7 only
// R12: program-once checks phrase erased, then programs, then verifies by read back
// R13: command complete flag stays low until program-once fully finished
// R14: program flash reads return invalid data while program-once runs
// R15: software issues program-once once per phrase, not from that block
// R16: one-time field readable through the read-once command
// R17: erase-block uses code 0x09, address bits 17:16 select the block
// R18: erase-block erases the block, verifies it erased, then sets complete
// R19: erase-block launched with index pointer not 001 sets access error
// R20: program-once phrase index above 7 sets access error, no programming
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH
`define FPS_CMD_PGM 8'h06
`define FPS_CMD_ONCE 8'h07
`define FPS_CMD_ERS 8'h09
`define FPS_CMD_RDO 8'h04
`define FPS_IDX_PGM 3'h5
`define FPS_IDX_ONCE 3'h5
`define FPS_IDX_ERS 3'h1
`define FPS_IDX_RDO 3'h1
`define FPS_ONCE_MAX 16'h0007
`define FPS_ONCE_BASE 18'h00000
`define FPS_ALIGN_ZERO 3'h0
`define FPS_INVALID_WORD 16'hffff
`endif

// ===== fps_pkg.sv
// types of the flash program and program-once sequencer
package fps_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CHK   = 8'h02,
    ST_BLANK = 8'h04,
    ST_PROG  = 8'h08,
    ST_VFY   = 8'h10,
    ST_ERASE = 8'h20,
    ST_RDO   = 8'h40,
    ST_EVFY  = 8'h80
  } fps_state_t;
  typedef enum logic [2:0] {
    OP_BLANK = 3'h0,
    OP_PROG  = 3'h1,
    OP_VFY   = 3'h2,
    OP_ERASE = 3'h3,
    OP_EVFY  = 3'h4,
    OP_READ  = 3'h5
  } fps_op_t;
  typedef struct packed {
    fps_op_t op;
    logic info;
    logic [17:0] addr;
    logic [63:0] wdata;
  } fps_nvm_cmd_t;
endpackage : fps_pkg

// ===== fps_flag.sv
// sticky status flag, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module fps_flag (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic set,
  input wire logic clr,
  // state
  output logic q_ff
);
  logic nxt_q;
  assign nxt_q = set | (q_ff & ~clr);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_ff <= 1'b0;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule : fps_flag
`default_nettype wire

// ===== fps_seq.sv
// flash command sequencer: program phrase, program once, read once, erase block
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"
module fps_seq #(
  parameter logic [17:0] PF_LO = 18'h00000,
  parameter logic [17:0] PF_HI = 18'h3ffff,
  parameter logic [1:0] PF_BLOCK = 2'h3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // parameter array write port
  input wire logic prm_wr,
  input wire logic [2:0] prm_idx,
  input wire logic [15:0] prm_data,
  // launch and flag clears
  input wire logic launch,
  input wire logic acc_clr,
  input wire logic viol_clr,
  // mode and protection
  input wire logic mode_ok,
  input wire logic prot_en,
  input wire logic [17:0] prot_lo,
  input wire logic [17:0] prot_hi,
  // nonvolatile array
  output logic nvm_req_ff,
  output fps_pkg::fps_nvm_cmd_t nvm_cmd_ff,
  input wire logic nvm_ack,
  input wire logic nvm_err,
  input wire logic nvm_uncorr,
  input wire logic [63:0] nvm_rdata,
  // cpu read path to program flash
  input wire logic [15:0] cpu_rd_in,
  output logic [15:0] cpu_rd_ff,
  // status
  output logic command_complete_flag_ff,
  output logic access_error_flag,
  output logic protection_violation_flag,
  output logic verify_error_status,
  output logic verify_uncorrectable_status,
  output logic [63:0] once_rdata_ff
);
  // ************************************************************
  // parameter array and pointer
  // ************************************************************
  logic [15:0] command_parameter_array [0:5];
  logic [2:0] command_index_pointer_ff;
  fps_pkg::fps_state_t state_ff;
  fps_pkg::fps_state_t nxt_state;
  wire prm_take = prm_wr & command_complete_flag_ff & (prm_idx < 3'h6);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      command_index_pointer_ff <= 3'h0;
    end else if (prm_take) begin
      command_index_pointer_ff <= prm_idx;
    end
  end
  always_ff @(posedge clk) begin
    if (prm_take) begin
      command_parameter_array[prm_idx] <= prm_data;
    end
  end
  // ************************************************************
  // launch checks
  // ************************************************************
  wire [7:0] code = command_parameter_array[0][15:8];
  wire [15:0] word1 = command_parameter_array[1];
  wire [17:0] addr = {command_parameter_array[0][1:0], word1};
  wire [2:0] ptr = command_index_pointer_ff;
  wire is_pgm = (code == `FPS_CMD_PGM);
  wire is_once = (code == `FPS_CMD_ONCE);
  wire is_ers = (code == `FPS_CMD_ERS);
  wire is_rdo = (code == `FPS_CMD_RDO);
  wire bad_code = ~(is_pgm | is_once | is_ers | is_rdo);
  wire in_range = (addr >= PF_LO) & (addr <= PF_HI);
  wire prot_hit = prot_en & (addr >= prot_lo) & (addr <= prot_hi);
  wire pgm_err = is_pgm & ((ptr != `FPS_IDX_PGM) | ~in_range
                 | (addr[2:0] != `FPS_ALIGN_ZERO)); // R1 R3 R4
  wire once_err = is_once & ((ptr != `FPS_IDX_ONCE) | (word1 > `FPS_ONCE_MAX)); // R20
  wire rdo_err = is_rdo & ((ptr != `FPS_IDX_RDO) | (word1 > `FPS_ONCE_MAX));
  wire ers_err = is_ers & ((ptr != `FPS_IDX_ERS)
                 | (command_parameter_array[0][1:0] != PF_BLOCK)); // R19 R17
  wire chk_acc = bad_code | ~mode_ok | pgm_err | once_err | rdo_err | ers_err; // R2
  wire chk_viol = ~chk_acc & ((is_pgm & prot_hit) | (is_ers & prot_en)); // R5
  wire in_chk = (state_ff == fps_pkg::ST_CHK);
  wire in_blank = (state_ff == fps_pkg::ST_BLANK);
  wire vfy_end = nvm_ack & ((state_ff == fps_pkg::ST_VFY) | (state_ff == fps_pkg::ST_EVFY));
  // only the one-time row is ever addressed with info set, and never for erase
  wire [17:0] once_addr = `FPS_ONCE_BASE + {12'h000, word1[2:0], 3'h0}; // R8 R9
  wire launch_ok = launch & command_complete_flag_ff;
  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fps_pkg::ST_IDLE: begin
        if (launch_ok) nxt_state = fps_pkg::ST_CHK;
      end
      fps_pkg::ST_CHK: begin
        if (chk_acc | chk_viol) nxt_state = fps_pkg::ST_IDLE;
        else if (is_pgm) nxt_state = fps_pkg::ST_PROG;
        else if (is_once) nxt_state = fps_pkg::ST_BLANK; // R12
        else if (is_ers) nxt_state = fps_pkg::ST_ERASE;
        else nxt_state = fps_pkg::ST_RDO;
      end
      fps_pkg::ST_BLANK: begin
        // a phrase already written is not erased: second program refused
        if (nvm_ack) nxt_state = nvm_err ? fps_pkg::ST_IDLE : fps_pkg::ST_PROG; // R9 R12
      end
      fps_pkg::ST_PROG: begin
        if (nvm_ack) nxt_state = fps_pkg::ST_VFY; // R12
      end
      fps_pkg::ST_ERASE: begin
        if (nvm_ack) nxt_state = fps_pkg::ST_EVFY; // R18
      end
      fps_pkg::ST_VFY, fps_pkg::ST_EVFY, fps_pkg::ST_RDO: begin
        if (nvm_ack) nxt_state = fps_pkg::ST_IDLE;
      end
      default: nxt_state = fps_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= fps_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end
  // ************************************************************
  // array requests
  // ************************************************************
  fps_pkg::fps_nvm_cmd_t nxt_cmd;
  logic nxt_req;
  wire nxt_is_op = (nxt_state != fps_pkg::ST_IDLE) & (nxt_state != fps_pkg::ST_CHK);
  wire once_cmd = is_once | is_rdo;
  assign nxt_req = nxt_is_op & ~nvm_ack;
  always_comb begin
    nxt_cmd.info = once_cmd;
    nxt_cmd.addr = once_cmd ? once_addr : addr;
    nxt_cmd.wdata = {command_parameter_array[5], command_parameter_array[4],
                     command_parameter_array[3], command_parameter_array[2]};
    case (nxt_state)
      fps_pkg::ST_BLANK: nxt_cmd.op = fps_pkg::OP_BLANK;
      fps_pkg::ST_PROG: nxt_cmd.op = fps_pkg::OP_PROG;
      fps_pkg::ST_VFY: nxt_cmd.op = fps_pkg::OP_VFY;
      fps_pkg::ST_ERASE: nxt_cmd.op = fps_pkg::OP_ERASE;
      fps_pkg::ST_EVFY: nxt_cmd.op = fps_pkg::OP_EVFY;
      fps_pkg::ST_RDO: nxt_cmd.op = fps_pkg::OP_READ;
      default: nxt_cmd.op = nvm_cmd_ff.op;
    endcase
  end
  // complete flag low from launch until the last array step ends
  wire nxt_command_complete_flag = launch_ok ? 1'b0 : (command_complete_flag_ff | (nxt_state == fps_pkg::ST_IDLE));
  // reads return junk while the one-time row is being written
  wire once_busy = is_once & (state_ff != fps_pkg::ST_IDLE);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nvm_req_ff <= 1'b0;
      nvm_cmd_ff <= '0;
      command_complete_flag_ff <= 1'b1;
      cpu_rd_ff <= 16'h0000;
      once_rdata_ff <= 64'h0;
    end else begin
      nvm_req_ff <= nxt_req;
      nvm_cmd_ff <= nxt_cmd;
      command_complete_flag_ff <= nxt_command_complete_flag; // R13
      cpu_rd_ff <= once_busy ? `FPS_INVALID_WORD : cpu_rd_in; // R14
      if (nvm_ack & (state_ff == fps_pkg::ST_RDO)) once_rdata_ff <= nvm_rdata; // R16
    end
  end
  // ************************************************************
  // status flags
  // ************************************************************
  fps_flag u_acc (.clk(clk), .rst_n(rst_n),
    .set((in_chk & chk_acc) | (in_blank & nvm_ack & nvm_err)), .clr(acc_clr),
    .q_ff(access_error_flag)); // R2 R9
  fps_flag u_viol (.clk(clk), .rst_n(rst_n), .set(in_chk & chk_viol), .clr(viol_clr),
    .q_ff(protection_violation_flag)); // R5
  fps_flag u_mg1 (.clk(clk), .rst_n(rst_n), .set(vfy_end & nvm_err), .clr(launch_ok),
    .q_ff(verify_error_status)); // R6
  fps_flag u_mg0 (.clk(clk), .rst_n(rst_n), .set(vfy_end & nvm_uncorr), .clr(launch_ok),
    .q_ff(verify_uncorrectable_status)); // R7
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_pgm_ptr: assert property (in_chk & is_pgm & (ptr != `FPS_IDX_PGM)
    |=> access_error_flag & (state_ff == fps_pkg::ST_IDLE)) // R1
    else $error("program with bad pointer not flagged");
  chk_mode_refuse: assert property (in_chk & ~mode_ok |=> ~nvm_req_ff & access_error_flag) // R2
    else $error("disallowed command ran");
  chk_pgm_range: assert property (in_chk & is_pgm & ~in_range |=> access_error_flag) // R3
    else $error("out of range address not flagged");
  chk_pgm_align: assert property (in_chk & is_pgm & (addr[2:0] != 3'h0)
    |=> ~nvm_req_ff & access_error_flag) // R4
    else $error("misaligned program started");
  chk_prot_viol: assert property (in_chk & ~chk_acc & is_pgm & prot_hit
    |=> protection_violation_flag & ~nvm_req_ff) // R5
    else $error("protected program not refused");
  chk_vfy_err: assert property (vfy_end & nvm_err |=> verify_error_status) // R6
    else $error("verify error lost");
  chk_vfy_uncorr: assert property (vfy_end & nvm_uncorr |=> verify_uncorrectable_status) // R7
    else $error("uncorrectable verify lost");
  chk_once_order: assert property (in_chk & is_once & ~chk_acc & ~chk_viol
    |=> nvm_req_ff & (nvm_cmd_ff.op == fps_pkg::OP_BLANK) & nvm_cmd_ff.info) // R12 R8
    else $error("program once did not start with erase check");
  chk_once_busy: assert property (once_busy & ~in_chk |-> ~command_complete_flag_ff) // R13
    else $error("complete flag set during program once");
  chk_rd_invalid: assert property (once_busy |=> cpu_rd_ff == `FPS_INVALID_WORD) // R14
    else $error("flash read not invalid during program once");
  chk_blank_refuse: assert property (in_blank & nvm_ack & nvm_err
    |=> access_error_flag & ~nvm_req_ff ##1 command_complete_flag_ff) // R9
    else $error("second program once not refused");
  chk_ers_seq: assert property ((state_ff == fps_pkg::ST_ERASE) & nvm_ack
    |=> ##1 nvm_cmd_ff.op == fps_pkg::OP_EVFY) // R18
    else $error("erase not followed by erase verify");
  chk_ers_ptr: assert property (in_chk & is_ers & (ptr != `FPS_IDX_ERS) |=> access_error_flag) // R19
    else $error("erase with bad pointer not flagged");
  chk_once_index: assert property (in_chk & is_once & (word1 > `FPS_ONCE_MAX)
    |=> access_error_flag & ~nvm_req_ff) // R20
    else $error("bad phrase index not refused");
  cov_once_done: cover property (in_blank & nvm_ack & ~nvm_err ##[1:400] vfy_end);
  cov_ers_done: cover property ((state_ff == fps_pkg::ST_EVFY) & nvm_ack);
  cov_pgm_viol: cover property (in_chk & chk_viol);
  cov_rdo_done: cover property ((state_ff == fps_pkg::ST_RDO) & nvm_ack);
endmodule : fps_seq
`default_nettype wire

// ===== fps_nvm_model.sv
// behavioural model of the nonvolatile array behind the sequencer
`timescale 1ns/1ps
`default_nettype none
module fps_nvm_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request side
  input wire logic req,
  input wire fps_pkg::fps_nvm_cmd_t cmd,
  // answer side
  output var logic ack,
  output var logic err,
  output var logic uncorr,
  output var logic [63:0] rdata,
  // test control: answer delay and verify fault 0 none, 1 error, 2 error plus uncorrectable
  input wire logic [3:0] dly,
  input wire logic [1:0] bad
);
  // ***********************
  // array and answer timing
  // ***********************
  logic [63:0] mem [8];
  logic [7:0] used_ff;
  logic [3:0] cnt_ff;
  wire logic [2:0] ph = cmd.addr[5:3];
  wire logic fire = req && !ack && cnt_ff == dly;
  wire logic vfy = cmd.op == fps_pkg::OP_VFY || cmd.op == fps_pkg::OP_EVFY;
  always_ff @(posedge clk) begin
    cnt_ff <= (!rst_n || !req || ack) ? 4'h0 : cnt_ff + 4'h1;
    ack <= rst_n && fire;
    // a once-row phrase already written fails its blank check
    err <= (cmd.info && cmd.op == fps_pkg::OP_BLANK && used_ff[ph]) || (vfy && bad != 2'h0);
    uncorr <= vfy && bad == 2'h2;
    // released data lines do not hold the last value
    rdata <= !rst_n ? 64'h0 : (fire ? mem[ph] : ~rdata);
    if (!rst_n) begin
      used_ff <= 8'h00;
    end else if (fire && cmd.info && cmd.op == fps_pkg::OP_PROG) begin
      used_ff[ph] <= 1'b1;
      mem[ph] <= cmd.wdata;
    end
  end
endmodule : fps_nvm_model
`default_nettype wire

// ===== testbench.sv
// self-checking testbench of the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ***********
  // stimulus
  // ***********
  logic clk = 1'b0, rst_n = 1'b0, prm_wr = 1'b0, launch = 1'b0, acc_clr = 1'b0;
  logic viol_clr = 1'b0, mode_ok = 1'b1, prot_en = 1'b0;
  logic [2:0] prm_idx = 3'h0;
  logic [15:0] prm_data = 16'h0;
  logic [3:0] dly = 4'h1;
  logic [1:0] bad = 2'h0;
  logic req, ack, err, unc_in, ccf, acc, viol, vfy, unc;
  fps_pkg::fps_nvm_cmd_t cmd;
  logic [63:0] rdata, once_q;
  logic [15:0] cpu_q;
  int n_mismatch = 0, comparisons = 0, t = 0;
  fps_seq #(.PF_HI(18'h1ffff)) dut_u (.clk(clk), .rst_n(rst_n), .prm_wr(prm_wr),
    .prm_idx(prm_idx), .prm_data(prm_data), .launch(launch), .acc_clr(acc_clr),
    .viol_clr(viol_clr), .mode_ok(mode_ok), .prot_en(prot_en), .prot_lo(18'h01000),
    .prot_hi(18'h01fff), .nvm_req_ff(req), .nvm_cmd_ff(cmd), .nvm_ack(ack), .nvm_err(err),
    .nvm_uncorr(unc_in), .nvm_rdata(rdata), .cpu_rd_in(16'h5a5a), .cpu_rd_ff(cpu_q),
    .command_complete_flag_ff(ccf), .access_error_flag(acc),
    .protection_violation_flag(viol), .verify_error_status(vfy),
    .verify_uncorrectable_status(unc), .once_rdata_ff(once_q));
  fps_nvm_model nvm_u (.clk(clk), .rst_n(rst_n), .req(req), .cmd(cmd), .ack(ack),
    .err(err), .uncorr(unc_in), .rdata(rdata), .dly(dly), .bad(bad));
  initial forever #25 clk = ~clk;
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // load word0 code and address high, word1, then data words up to index n-1
  task automatic cmd_load(input logic [7:0] code, input logic [1:0] ahi,
                          input logic [15:0] w1, input int n);
    for (int i = 0; i < n; i++) begin
      prm_wr <= 1'b1;
      prm_idx <= 3'(i);
      prm_data <= i == 0 ? {code, 6'h0, ahi} : (i == 1 ? w1 : 16'hc0d0 + 16'(i));
      @(posedge clk);
    end
    prm_wr <= 1'b0;
  endtask : cmd_load
  // launch, look at the busy window, then wait for completion
  task automatic go(input logic once);
    launch <= 1'b1;
    @(posedge clk);
    launch <= 1'b0;
    // the flag drops in the check cycle; a refused command raises it again one edge later
    #1 cmp(ccf, 1'b0);
    @(posedge clk);
    #1 if (once) cmp(cpu_q, 16'hffff);
    for (int i = 0; i < 300 && !ccf; i++) begin
      @(posedge clk);
      #1;
    end
    #1 if (!ccf) begin
      n_mismatch++;
      $display("[FAIL] %0t completion never came", $time);
      wrap_up();
    end
  endtask : go
  // compare status flags, then clear the access error and protection violation flags
  task automatic st(input logic [3:0] e);
    cmp({acc, viol, vfy, unc}, e);
    acc_clr <= 1'b1;
    viol_clr <= 1'b1;
    @(posedge clk);
    acc_clr <= 1'b0;
    viol_clr <= 1'b0;
    @(posedge clk);
    t++;
    $display("test %0d done", t);
  endtask : st
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 cmp({ccf, acc, viol, vfy, unc}, 5'b10000);
    cmd_load(8'h06, 2'h0, 16'h0100, 5); go(0); st(4'b1000);
    mode_ok <= 1'b0;
    cmd_load(8'h06, 2'h0, 16'h0100, 6); go(0); st(4'b1000);
    mode_ok <= 1'b1;
    cmd_load(8'h06, 2'h2, 16'h0000, 6); go(0); st(4'b1000);
    cmd_load(8'h06, 2'h0, 16'h0104, 6); go(0); st(4'b1000);
    prot_en <= 1'b1;
    cmd_load(8'h06, 2'h0, 16'h1008, 6); go(0); st(4'b0100);
    cmd_load(8'h09, 2'h3, 16'h0000, 2); go(0); st(4'b0100);
    prot_en <= 1'b0;
    bad <= 2'h1;
    cmd_load(8'h06, 2'h0, 16'h0100, 6); go(0); st(4'b0010);
    bad <= 2'h2;
    cmd_load(8'h06, 2'h0, 16'h0108, 6); go(0); st(4'b0011);
    bad <= 2'h0;
    dly <= 4'h6;
    cmd_load(8'h07, 2'h0, 16'h0003, 6); go(1); st(4'b0000);
    cmd_load(8'h04, 2'h0, 16'h0003, 2); go(0); st(4'b0000);
    cmp(once_q, 64'hc0d5c0d4c0d3c0d2);
    cmd_load(8'h07, 2'h0, 16'h0003, 6); go(1); st(4'b1000);
    cmd_load(8'h07, 2'h0, 16'h0008, 6); go(1); st(4'b1000);
    dly <= 4'h1;
    cmd_load(8'h09, 2'h3, 16'h0000, 1); go(0); st(4'b1000);
    cmd_load(8'h09, 2'h3, 16'h0000, 2); go(0); st(4'b0000);
    cmp(cpu_q, 16'h5a5a);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
